/* pkg/bmsd_pkg.sv */
// Package for the boot mode select decoder: boot addresses, modes and timing
package bmsd_pkg;

  localparam int unsigned ADDR_W        = 22;
  localparam logic [21:0] FLASH_ENTRY   = 22'h3f7ff6;
  localparam logic [21:0] HIGH_SRAM_ENT = 22'h3f8000;
  localparam logic [21:0] OTP_ENTRY     = 22'h3d7800;
  localparam logic [21:0] NO_ADDR       = 22'h000000;

  // Settle time after reset release before the straps are captured
  localparam int unsigned SETTLE_NS     = 100;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SETTLE_CYC_W  = 4'(SETTLE_CYC);

  typedef enum logic [2:0] {
    BMSD_BOOT_FLASH,
    BMSD_BOOT_SERIAL_EEPROM,
    BMSD_BOOT_ASYNC_SERIAL,
    BMSD_BOOT_HIGH_SRAM,
    BMSD_BOOT_OTP,
    BMSD_BOOT_PARALLEL,
    BMSD_BOOT_EXTERNAL
  } bmsd_mode_t;

endpackage

/* rtl/bmsd_decoder.sv */
// Boot mode select decoder: captures straps after reset and picks the boot path
`timescale 1ns/100ps
`default_nettype none

module bmsd_decoder
  import bmsd_pkg::*;
#(
  // Capture delay after reset release, in clock cycles
  parameter int unsigned SETTLE_COUNT = SETTLE_CYC
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // Strap pins, asynchronous to i_clk
  input  wire logic              i_boot_sel_a,
  input  wire logic              i_boot_sel_b,
  input  wire logic              i_boot_sel_c,
  input  wire logic              i_boot_sel_d,
  input  wire logic              i_processor_mode_strap,
  // Boot decision
  output logic                   o_done,
  output var bmsd_mode_t         o_mode,
  output logic [ADDR_W-1:0]      o_jump_addr,
  output logic                   o_jump,
  output logic                   o_serial_eeprom_load,
  output logic                   o_async_serial_load,
  output logic                   o_parallel_port_load,
  output logic                   o_external_fetch
);

  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [3:0] settle_q;
  logic       done_q;
  bmsd_mode_t mode_d;

  // Four-bit counter; at least two cycles so that sync2 holds samples
  // taken after the release and not the reset pattern.
  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_COUNT);

  if (SETTLE_COUNT < 2 || SETTLE_COUNT > 15) begin : g_settle_check
    $error("SETTLE_COUNT outside the range the settle counter serves");
  end

  function automatic bmsd_mode_t decode(input logic [3:0] sel, input logic mp);
    if (mp)
      return BMSD_BOOT_EXTERNAL;
    if (sel[3])
      return BMSD_BOOT_FLASH;
    if (sel[2])
      return BMSD_BOOT_SERIAL_EEPROM;
    case (sel[1:0])
      2'b11:   return BMSD_BOOT_ASYNC_SERIAL;
      2'b10:   return BMSD_BOOT_HIGH_SRAM;
      2'b01:   return BMSD_BOOT_OTP;
      default: return BMSD_BOOT_PARALLEL;
    endcase
  endfunction

  // Jump modes run from on-chip memory and pull in no external image
  function automatic logic is_jump(input bmsd_mode_t m);
    return m == BMSD_BOOT_FLASH || m == BMSD_BOOT_HIGH_SRAM || m == BMSD_BOOT_OTP;
  endfunction

  // Pins are asynchronous: two stages before anything looks at them.
  // Reset value of sel_a is 1 to match its pull-up.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= 5'h08;
      sync2_q <= 5'h08;
    end else begin
      sync1_q <= {i_processor_mode_strap, i_boot_sel_a, i_boot_sel_b,
                  i_boot_sel_c, i_boot_sel_d};
      sync2_q <= sync1_q;
    end
  end

  // Wait for the synchroniser to fill and straps to settle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst)
      settle_q <= 4'h0;
    else if (settle_q != SETTLE_LAST)
      settle_q <= settle_q + 4'h1;
  end

  assign mode_d = decode(sync2_q[3:0], sync2_q[4]);

  // One capture only; the decision then holds until the next reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      done_q <= 1'b0;
      o_mode <= BMSD_BOOT_FLASH;
    end else if (!done_q && settle_q == SETTLE_LAST) begin
      done_q <= 1'b1;
      o_mode <= mode_d;
    end
  end

  // Outputs registered from the captured mode
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_jump_addr          <= NO_ADDR;
      o_jump               <= 1'b0;
      o_serial_eeprom_load <= 1'b0;
      o_async_serial_load  <= 1'b0;
      o_parallel_port_load <= 1'b0;
      o_external_fetch     <= 1'b0;
      o_done               <= 1'b0;
    end else begin
      o_done               <= done_q;
      o_jump               <= done_q && is_jump(o_mode);
      o_serial_eeprom_load <= done_q && o_mode == BMSD_BOOT_SERIAL_EEPROM;
      o_async_serial_load  <= done_q && o_mode == BMSD_BOOT_ASYNC_SERIAL;
      o_parallel_port_load <= done_q && o_mode == BMSD_BOOT_PARALLEL;
      o_external_fetch     <= done_q && o_mode == BMSD_BOOT_EXTERNAL;
      case (o_mode)
        BMSD_BOOT_FLASH:     o_jump_addr <= done_q ? FLASH_ENTRY : NO_ADDR;
        BMSD_BOOT_HIGH_SRAM: o_jump_addr <= done_q ? HIGH_SRAM_ENT : NO_ADDR;
        BMSD_BOOT_OTP:       o_jump_addr <= done_q ? OTP_ENTRY : NO_ADDR;
        default:             o_jump_addr <= NO_ADDR;
      endcase
    end
  end

  // Assertions: strap values are seen in sync2 one edge before done_q rises
  // Capture timing
  a_capture_once: assert property (@(posedge i_clk) disable iff (!i_nrst)
    done_q && $past(done_q) |-> $stable(o_mode))
    else $error("boot mode changed after capture");

  a_capture_time: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) |-> $past(settle_q) == SETTLE_LAST)
    else $error("capture at wrong time");

  a_done_timing: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) |=> $rose(o_done))
    else $error("decision not shown one edge after capture");

  a_done_holds: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_done |=> o_done)
    else $error("decision dropped before reset");

  // Decode of each strap pattern
  a_flash_addr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    done_q && o_mode == BMSD_BOOT_FLASH |=> o_jump && o_jump_addr == FLASH_ENTRY)
    else $error("flash entry address wrong");

  a_sel_a_wins: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) && !$past(sync2_q[4]) && $past(sync2_q[3])
    |=> o_jump && o_jump_addr == FLASH_ENTRY && !o_serial_eeprom_load)
    else $error("boot_sel_a high did not select flash");

  a_eeprom_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) && !$past(sync2_q[4]) && !$past(sync2_q[3]) && $past(sync2_q[2])
    |=> o_serial_eeprom_load)
    else $error("serial EEPROM load not chosen");

  a_async_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) && $past(sync2_q) == 5'h03 |=> o_async_serial_load)
    else $error("async serial load not chosen");

  a_sram_addr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) && $past(sync2_q) == 5'h02 |=> o_jump_addr == HIGH_SRAM_ENT)
    else $error("high SARAM entry wrong");

  a_otp_addr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) && $past(sync2_q) == 5'h01 |=> o_jump_addr == OTP_ENTRY)
    else $error("OTP entry wrong");

  a_parallel_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) && $past(sync2_q) == 5'h00 |=> o_parallel_port_load)
    else $error("parallel load not chosen");

  a_external_mode: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) && $past(sync2_q[4]) |=> o_external_fetch && !o_jump)
    else $error("processor mode strap ignored");

  a_rom_mode: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(done_q) && !$past(sync2_q[4]) |=> o_done && !o_external_fetch)
    else $error("boot ROM decode not taken with mode strap low");

  // Output shape before and after the decision
  a_jump_no_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_jump |-> !o_serial_eeprom_load && !o_async_serial_load && !o_parallel_port_load)
    else $error("jump mode also loads code");

  a_load_no_addr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_jump |-> o_jump_addr == NO_ADDR)
    else $error("jump address shown in a load mode");

  a_outputs_onehot: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_done |-> $onehot({o_jump, o_serial_eeprom_load, o_async_serial_load,
                        o_parallel_port_load, o_external_fetch}))
    else $error("boot outputs not one-hot");

  a_quiet_before: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_done |-> !o_jump && !o_serial_eeprom_load && !o_async_serial_load &&
                !o_parallel_port_load && !o_external_fetch && o_jump_addr == NO_ADDR)
    else $error("boot output active before the decision");

  a_outputs_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_done && $past(o_done) |-> $stable(o_jump_addr) && $stable(o_jump) &&
      $stable(o_serial_eeprom_load) && $stable(o_async_serial_load) &&
      $stable(o_parallel_port_load) && $stable(o_external_fetch))
    else $error("boot outputs changed after the decision");

endmodule // bmsd_decoder

`default_nettype wire

/* testbench/bmsd_board.sv */
// Board strap model: drives the boot straps, pull-up on the first one
`timescale 1ns/100ps
`default_nettype none
module bmsd_board (
  // Strap settings from the bench
  input  wire logic       i_drive_a,
  input  wire logic [3:0] i_sel,
  input  wire logic       i_pmode,
  // Strap pins, a/b/c/d from bit 3 down
  output logic      [3:0] o_pin,
  output logic            o_pmode
);
  // Undriven first strap floats up; the rest are always driven
  assign o_pin = {i_drive_a ? i_sel[3] : 1'b1, i_sel[2:0]};
  // The branch at the flash entry is board content, taken as present
  assign o_pmode = i_pmode;
endmodule // bmsd_board
`default_nettype wire

/* testbench/boot_mode_select_decoder_test.sv */
// Self-checking bench for the boot mode select decoder
`timescale 1ns/100ps
`default_nettype none
module boot_mode_select_decoder_test;
  import bmsd_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, drv_a = 1'b1, pm = 1'b0, pm_pin;
  logic [3:0] sel = 4'h0, pin;
  logic done, jmp, ee, asy, par, ext;
  bmsd_mode_t mode;
  logic [ADDR_W-1:0] addr;
  int err_count = 0, num_checks = 0, cyc = 0;
  initial forever #12.5 clk = ~clk;
  bmsd_board brd (.i_drive_a(drv_a), .i_sel(sel), .i_pmode(pm), .o_pin(pin), .o_pmode(pm_pin));
  bmsd_decoder uut (.i_clk(clk), .i_nrst(nrst), .i_boot_sel_a(pin[3]), .i_boot_sel_b(pin[2]),
    .i_boot_sel_c(pin[1]), .i_boot_sel_d(pin[0]), .i_processor_mode_strap(pm_pin),
    .o_done(done), .o_mode(mode), .o_jump_addr(addr), .o_jump(jmp),
    .o_serial_eeprom_load(ee), .o_async_serial_load(asy), .o_parallel_port_load(par),
    .o_external_fetch(ext));
  function automatic bmsd_mode_t exp_mode(input logic [3:0] s, input logic p);
    if (p) return BMSD_BOOT_EXTERNAL;
    if (s[3]) return BMSD_BOOT_FLASH;
    if (s[2]) return BMSD_BOOT_SERIAL_EEPROM;
    case (s[1:0])
      2'h3: return BMSD_BOOT_ASYNC_SERIAL;
      2'h2: return BMSD_BOOT_HIGH_SRAM;
      2'h1: return BMSD_BOOT_OTP;
      default: return BMSD_BOOT_PARALLEL;
    endcase
  endfunction
  function automatic logic [26:0] exp_out(input bmsd_mode_t m);
    logic [ADDR_W-1:0] a;
    a = m == BMSD_BOOT_FLASH ? FLASH_ENTRY : m == BMSD_BOOT_HIGH_SRAM ? HIGH_SRAM_ENT :
        m == BMSD_BOOT_OTP ? OTP_ENTRY : NO_ADDR;
    return {a, m inside {BMSD_BOOT_FLASH, BMSD_BOOT_HIGH_SRAM, BMSD_BOOT_OTP},
      m == BMSD_BOOT_SERIAL_EEPROM, m == BMSD_BOOT_ASYNC_SERIAL,
      m == BMSD_BOOT_PARALLEL, m == BMSD_BOOT_EXTERNAL};
  endfunction
  task automatic chk_mode(input bmsd_mode_t got, input bmsd_mode_t exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected mode t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bits(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected outputs t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One full boot per call: straps settle during reset, then change after the decision
  task automatic run(input logic [3:0] s, input logic p, input logic da);
    bmsd_mode_t m;
    int n;
    nrst = 1'b0;
    sel = s;
    pm = p;
    drv_a = da;
    m = exp_mode({da ? s[3] : 1'b1, s[2:0]}, p);
    repeat (2) @(posedge clk);
    #2 nrst = 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #2 n++;
    end
    chk_bits({31'h0, done}, 32'h1);
    chk_mode(mode, m);
    chk_bits({5'h0, addr, jmp, ee, asy, par, ext}, {5'h0, exp_out(m)});
    sel = ~s;
    pm = ~p;
    repeat (6) @(posedge clk);
    #2 chk_mode(mode, m);
    chk_bits({5'h0, addr, jmp, ee, asy, par, ext}, {5'h0, exp_out(m)});
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(46));
    // The first run adds two reset edges: twelve before the first release
    repeat (10) @(posedge clk);
    #2;
    for (int i = 0; i < 48; i++) begin
      if (i < 32) run(i[3:0], i[4], 1'b1);
      else if (i == 32) run(4'h0, 1'b0, 1'b0);
      else run(4'($urandom), 1'($urandom), 1'($urandom));
      $display("test %0d done", i);
    end
    tally_and_finish();
  end
endmodule // boot_mode_select_decoder_test
`default_nettype wire
